// ### logic/ssc_regs.vh
// constants for the soft switch configuration panel
// assumes a 25 MHz system clock; included by ssc_panel.v
`ifndef SSC_REGS_VH
`define SSC_REGS_VH
`define SSC_CLK_HZ 25000000
`define SSC_TIMEOUT_S 20
`define SSC_TIMEOUT_CYC (`SSC_TIMEOUT_S * `SSC_CLK_HZ)
`define SSC_DEBOUNCE_MS 10
`define SSC_DEBOUNCE_CYC (`SSC_DEBOUNCE_MS * (`SSC_CLK_HZ / 1000))
`define SSC_TRUNK_BPS 9600
`define SSC_TRUNK_DIV (`SSC_CLK_HZ / (2 * `SSC_TRUNK_BPS))
`define SSC_EXT_MAX_BPS 19200
`define SSC_EXT_MIN_HALF (`SSC_CLK_HZ / (2 * `SSC_EXT_MAX_BPS))
`define SSC_SEL_EXT_CLK 1
`define SSC_SEL_COLD 3
`define SSC_SEL_SUBADDR 4
`define SSC_SEL_BIAS 0
`define SSC_GRP_NONE 2'h0
`define SSC_GRP_ONE 2'h1
`define SSC_GRP_TWO 2'h2
`define SSC_GRP_THREE 2'h3
`define SSC_DEF_ONE 8'h00
`define SSC_DEF_TWO 8'h00
`define SSC_DEF_THREE 8'h00
`endif

// ### logic/ssc_panel.v
// soft switch configuration panel: three switch groups, lamps, timeout,
// nonvolatile copy and the run-time effects of the switches
// assumes keys and status inputs synchronous to ref_clk; nvm is a simple
// word store that acks writes and reports a load failure at start
//
// Overview of operation
// [R1] group key enters configure mode, lamps show group
// [R2] group key starts twenty second display timeout
// [R3] further keys reload timeout to full
// [R4] timeout expiry returns lamps to status
// [R5] value key n toggles selection n
// [R6] selection n drives indicator lamp n
// [R7] both reset keys reset, commit, light lamps
// [R8] group one sel2 off: own 9600 trunk clock
// [R9] group one sel2 on: external clock up to 19.2k
// [R10] accept call only on matching group number
// [R11] route by subaddress, command uses sel5 type
// [R12] bias off: open control input reads inactive
// [R13] bias on: open control input reads active
// [R14] driven control inputs follow actual level
// [R15] store changes at once, apply after reset
// [R16] alarm lamp on storage failure or battery low
// [R17] subaddress and group number only on cold start
// [R18] cold start clears group one sel4 afterwards
// [R19] one group edited at a time
// [R20] keys debounced and edge detected
//
`timescale 1ns/1ps
`include "ssc_regs.vh"
module ssc_panel #(
  parameter TIMEOUT_CYC = `SSC_TIMEOUT_CYC,
  parameter DEBOUNCE_CYC = `SSC_DEBOUNCE_CYC,
  parameter NCTL = 6
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [2:0] group_key,
  input wire [7:0] value_key,
  input wire [1:0] reset_key,
  input wire [7:0] status_lamp,
  input wire nvm_fail,
  input wire battery_low,
  input wire nvm_load_valid,
  input wire [7:0] nvm_load_one,
  input wire [7:0] nvm_load_two,
  input wire [7:0] nvm_load_three,
  input wire nvm_write_ack,
  input wire ext_trunk_clk,
  input wire call_valid,
  input wire [3:0] call_group,
  input wire [1:0] call_subaddr_line,
  input wire call_is_command,
  input wire call_cmd_x121,
  input wire [NCTL-1:0] ctl_level,
  input wire [NCTL-1:0] ctl_connected,
  output reg indicator_lamp_1,
  output reg indicator_lamp_2,
  output reg indicator_lamp_3,
  output reg indicator_lamp_4,
  output reg config_alarm_lamp,
  output reg indicator_lamp_6,
  output reg indicator_lamp_7,
  output reg indicator_lamp_8,
  output reg configure_mode,
  output reg unit_reset,
  output reg nvm_write,
  output reg [1:0] nvm_write_group,
  output reg [7:0] nvm_write_data,
  output reg trunk_clk_out,
  output reg trunk_clk_int,
  output reg ext_clk_too_fast,
  output reg call_accept,
  output reg call_reject,
  output reg [1:0] call_line,
  output reg call_to_command,
  output reg [NCTL-1:0] ctl_active,
  output reg [7:0] switch_group_one,
  output reg [7:0] switch_group_two,
  output reg [7:0] switch_group_three
);

  localparam ST_RUN = 2'h0;
  localparam ST_RESET = 2'h1;
  localparam ST_COMMIT = 2'h2;
  localparam [31:0] TRUNK_DIV = `SSC_TRUNK_DIV;
  localparam [31:0] EXT_MIN = `SSC_EXT_MIN_HALF;

  function [7:0] pick_group;
    input [1:0] g;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    begin
      case (g)
        `SSC_GRP_ONE: pick_group = a;
        `SSC_GRP_TWO: pick_group = b;
        `SSC_GRP_THREE: pick_group = c;
        default: pick_group = 8'h00;
      endcase
    end
  endfunction

  // debounce: a key must hold its level for DEBOUNCE_CYC before it counts
  // any key change restarts the count, so a chord registers as one event
  wire [12:0] raw_keys = {reset_key, group_key, value_key};
  reg [12:0] stable;
  reg [12:0] stable_d;
  reg [12:0] last_raw;
  reg [31:0] bounce_cnt;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stable <= 13'h0000;
      stable_d <= 13'h0000;
      last_raw <= 13'h0000;
      bounce_cnt <= 32'h00000000;
    end else begin
      stable_d <= stable;
      last_raw <= raw_keys;
      if (raw_keys != last_raw) begin
        bounce_cnt <= 32'h00000000; // [R20]
      end else if (bounce_cnt < DEBOUNCE_CYC) begin
        bounce_cnt <= bounce_cnt + 32'h00000001;
      end else begin
        stable <= raw_keys;
      end
    end
  end
  wire [12:0] press = stable & ~stable_d; // [R20]
  wire [7:0] val_press = press[7:0];
  wire [2:0] grp_press = press[10:8];
  wire both_reset = stable[12] & stable[11]; // [R7]

  // edited copy is what storage holds; live copy is what operation uses
  reg [7:0] edit_one;
  reg [7:0] edit_two;
  reg [7:0] edit_three;
  reg [1:0] group_sel;
  reg [31:0] timeout_cnt;
  reg [1:0] state;
  reg cold_pending;
  reg nvm_loaded;
  reg nvm_bad;
  reg [3:0] live_group_number;
  reg live_cmd_x121;
  reg [1:0] pend_group;
  reg [7:0] pend_data;
  reg pend_busy;

  wire any_key = (|grp_press) | (|val_press);
  wire [1:0] next_group = grp_press[0] ? `SSC_GRP_ONE :
                          grp_press[1] ? `SSC_GRP_TWO :
                          grp_press[2] ? `SSC_GRP_THREE : group_sel;
  wire [7:0] shown = pick_group(group_sel, edit_one, edit_two, edit_three);

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      edit_one <= `SSC_DEF_ONE;
      edit_two <= `SSC_DEF_TWO;
      edit_three <= `SSC_DEF_THREE;
      switch_group_one <= `SSC_DEF_ONE;
      switch_group_two <= `SSC_DEF_TWO;
      switch_group_three <= `SSC_DEF_THREE;
      live_group_number <= 4'h0;
      live_cmd_x121 <= 1'b0;
      group_sel <= `SSC_GRP_NONE;
      timeout_cnt <= 32'h00000000;
      configure_mode <= 1'b0;
      state <= ST_RUN;
      unit_reset <= 1'b0;
      cold_pending <= 1'b0;
      nvm_loaded <= 1'b0;
      nvm_bad <= 1'b0;
      pend_busy <= 1'b0;
      pend_group <= 2'h0;
      pend_data <= 8'h00;
      nvm_write <= 1'b0;
      nvm_write_group <= 2'h0;
      nvm_write_data <= 8'h00;
    end else begin
      nvm_write <= 1'b0;
      if (nvm_load_valid && !nvm_loaded) begin
        nvm_loaded <= 1'b1;
        nvm_bad <= nvm_fail; // [R16]
        if (!nvm_fail) begin
          edit_one <= nvm_load_one;
          edit_two <= nvm_load_two;
          edit_three <= nvm_load_three;
          switch_group_one <= nvm_load_one;
          switch_group_two <= nvm_load_two;
          switch_group_three <= nvm_load_three;
          live_group_number <= nvm_load_two[3:0];
          live_cmd_x121 <= nvm_load_two[`SSC_SEL_SUBADDR];
        end
      end
      // clear before the state case: a write queued in the same cycle wins
      if (pend_busy && !nvm_write && nvm_write_ack) begin
        pend_busy <= 1'b0;
      end
      case (state)
        ST_RUN: begin
          if (both_reset) begin
            state <= ST_RESET;
            unit_reset <= 1'b1; // [R7]
            configure_mode <= 1'b0;
            group_sel <= `SSC_GRP_NONE;
            cold_pending <= edit_one[`SSC_SEL_COLD]; // [R18]
          end else begin
            // the display timer runs only in configure mode; every group or value key press reloads it
            if (|grp_press) begin
              group_sel <= next_group; // [R19]
              configure_mode <= 1'b1; // [R1]
              timeout_cnt <= TIMEOUT_CYC; // [R2]
            end else if (configure_mode && any_key) begin
              timeout_cnt <= TIMEOUT_CYC; // [R3]
            end else if (configure_mode) begin
              if (timeout_cnt <= 32'h00000001) begin
                configure_mode <= 1'b0; // [R4]
                group_sel <= `SSC_GRP_NONE;
              end
              timeout_cnt <= timeout_cnt - 32'h00000001;
            end
            if (configure_mode && !(|grp_press) && |val_press && !pend_busy) begin
              pend_busy <= 1'b1;
              pend_group <= group_sel;
              pend_data <= shown ^ val_press; // [R15]
              case (group_sel)
                `SSC_GRP_ONE: edit_one <= edit_one ^ val_press; // [R5]
                `SSC_GRP_TWO: edit_two <= edit_two ^ val_press; // [R5]
                `SSC_GRP_THREE: edit_three <= edit_three ^ val_press; // [R5]
                default: edit_one <= edit_one;
              endcase
            end
          end
        end
        ST_RESET: begin
          if (!both_reset) begin
            state <= ST_COMMIT;
          end
        end
        ST_COMMIT: begin
          // warm start applies everything but subaddress type, group number and group one sel4
          unit_reset <= 1'b0;
          state <= ST_RUN;
          switch_group_one <= edit_one & ~(8'h01 << `SSC_SEL_COLD); // [R15]
          switch_group_two <= edit_two;
          switch_group_three <= edit_three;
          if (cold_pending) begin
            live_group_number <= edit_two[3:0]; // [R17]
            live_cmd_x121 <= edit_two[`SSC_SEL_SUBADDR]; // [R17]
            edit_one <= edit_one & ~(8'h01 << `SSC_SEL_COLD); // [R18]
            pend_busy <= 1'b1;
            pend_group <= `SSC_GRP_ONE;
            pend_data <= edit_one & ~(8'h01 << `SSC_SEL_COLD); // [R18]
          end
          cold_pending <= 1'b0;
        end
        default: state <= ST_RUN;
      endcase
      // one write in flight; a toggle during a pending write is dropped
      if (pend_busy && !nvm_write && !nvm_write_ack && nvm_write_group != pend_group) begin
        nvm_write <= 1'b1; // [R15]
        nvm_write_group <= pend_group;
        nvm_write_data <= pend_data;
      end else if (pend_busy && !nvm_write && !nvm_write_ack && nvm_write_data != pend_data) begin
        nvm_write <= 1'b1; // [R15]
        nvm_write_data <= pend_data;
      end
    end
  end

  // lamps: reset lights all, configure shows group, else status
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {indicator_lamp_8, indicator_lamp_7, indicator_lamp_6, config_alarm_lamp,
       indicator_lamp_4, indicator_lamp_3, indicator_lamp_2, indicator_lamp_1} <= 8'hFF;
    end else if (unit_reset || both_reset) begin
      {indicator_lamp_8, indicator_lamp_7, indicator_lamp_6, config_alarm_lamp,
       indicator_lamp_4, indicator_lamp_3, indicator_lamp_2, indicator_lamp_1} <= 8'hFF; // [R7]
    end else if (configure_mode) begin
      {indicator_lamp_8, indicator_lamp_7, indicator_lamp_6, config_alarm_lamp,
       indicator_lamp_4, indicator_lamp_3, indicator_lamp_2, indicator_lamp_1} <= shown; // [R6]
    end else begin
      {indicator_lamp_8, indicator_lamp_7, indicator_lamp_6, config_alarm_lamp,
       indicator_lamp_4, indicator_lamp_3, indicator_lamp_2, indicator_lamp_1} <=
        {status_lamp[7:5], status_lamp[4] | nvm_bad | battery_low, status_lamp[3:0]}; // [R4] [R16]
    end
  end

  // trunk clock: internal divider or external passthrough
  // with the external clock selected, edges closer than the 19.2k half period raise ext_clk_too_fast
  reg [31:0] div_cnt;
  reg ext_d;
  reg [31:0] ext_half;
  wire use_ext = switch_group_one[`SSC_SEL_EXT_CLK];
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 32'h00000000;
      trunk_clk_int <= 1'b0;
      trunk_clk_out <= 1'b0;
      ext_d <= 1'b0;
      ext_half <= 32'h00000000;
      ext_clk_too_fast <= 1'b0;
    end else begin
      ext_d <= ext_trunk_clk;
      if (div_cnt >= TRUNK_DIV - 32'h00000001) begin
        div_cnt <= 32'h00000000;
        trunk_clk_int <= ~trunk_clk_int; // [R8]
      end else begin
        div_cnt <= div_cnt + 32'h00000001;
      end
      trunk_clk_out <= use_ext ? ext_trunk_clk : trunk_clk_int; // [R8] [R9]
      if (ext_d != ext_trunk_clk) begin
        ext_half <= 32'h00000000;
        ext_clk_too_fast <= use_ext && (ext_half + 32'h00000001 < EXT_MIN); // [R9]
      end else if (ext_half != 32'hFFFFFFFF) begin
        ext_half <= ext_half + 32'h00000001;
      end
    end
  end

  // incoming call screening and control input bias
  // group number and subaddress type are live copies, set at load or cold start
  wire bias_on = switch_group_three[`SSC_SEL_BIAS];
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      call_accept <= 1'b0;
      call_reject <= 1'b0;
      call_line <= 2'h0;
      call_to_command <= 1'b0;
      ctl_active <= {NCTL{1'b0}};
    end else begin
      call_accept <= call_valid && (call_group == live_group_number); // [R10]
      call_reject <= call_valid && (call_group != live_group_number); // [R10]
      if (call_valid) begin
        call_line <= call_subaddr_line; // [R11]
        call_to_command <= call_is_command && (call_cmd_x121 == live_cmd_x121); // [R11]
      end
      // [R12] [R13] [R14]
      ctl_active <= (ctl_level & ctl_connected) | ({NCTL{bias_on}} & ~ctl_connected);
    end
  end

endmodule

// ### testbench/ssc_panel_asserts.sv
// port checker for the soft switch panel
// assumes one clock ref_clk and async active-low rst_b
`timescale 1ns/1ps
module ssc_panel_asserts #(
  parameter TIMEOUT_CYC = 50,
  parameter DEBOUNCE_CYC = 2,
  parameter NCTL = 6
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [2:0] group_key,
  input wire [7:0] value_key,
  input wire battery_low,
  input wire ext_trunk_clk,
  input wire call_valid,
  input wire [NCTL-1:0] ctl_level,
  input wire [NCTL-1:0] ctl_connected,
  input wire indicator_lamp_1,
  input wire indicator_lamp_2,
  input wire indicator_lamp_3,
  input wire indicator_lamp_4,
  input wire config_alarm_lamp,
  input wire indicator_lamp_6,
  input wire indicator_lamp_7,
  input wire indicator_lamp_8,
  input wire configure_mode,
  input wire unit_reset,
  input wire nvm_write,
  input wire [1:0] nvm_write_group,
  input wire trunk_clk_out,
  input wire trunk_clk_int,
  input wire call_accept,
  input wire call_reject,
  input wire [NCTL-1:0] ctl_active,
  input wire [7:0] switch_group_one,
  input wire [7:0] switch_group_three
);
  wire [7:0] lamps = {indicator_lamp_8, indicator_lamp_7, indicator_lamp_6, config_alarm_lamp,
    indicator_lamp_4, indicator_lamp_3, indicator_lamp_2, indicator_lamp_1};
  wire [NCTL-1:0] want = (ctl_level & ctl_connected) | (~ctl_connected & {NCTL{switch_group_three[0]}});
  reg [10:0] prev_keys;
  reg [31:0] idle;
  // counts from the touch, so it runs ahead of the debounced press
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_keys <= 11'h000;
      idle <= 32'h0;
    end else begin
      prev_keys <= {group_key, value_key};
      idle <= (|({group_key, value_key} & ~prev_keys)) ? 32'h0 : idle + 32'h1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  lamps_on_a: assert property (unit_reset |-> &lamps)
    else $error("lamps dark in reset");
  call_answer_a: assert property (call_valid |=> call_accept != call_reject)
    else $error("call not answered once");
  trunk_src_a: assert property ($stable(switch_group_one[1]) |->
    trunk_clk_out == (switch_group_one[1] ? $past(ext_trunk_clk) : $past(trunk_clk_int)))
    else $error("trunk source wrong");
  ctl_bias_a: assert property ($stable(want) [*3] |-> ctl_active == want)
    else $error("control input reading wrong");
  idle_off_a: assert property (idle > TIMEOUT_CYC + DEBOUNCE_CYC + 8 |-> !configure_mode)
    else $error("display timeout overran");
  timer_reload_a: assert property ($fell(configure_mode) && !unit_reset && !$past(unit_reset) |->
    idle >= TIMEOUT_CYC) else $error("display timeout too early");
  alarm_lamp_a: assert property ((battery_low && !configure_mode && !unit_reset) [*3] |-> config_alarm_lamp)
    else $error("alarm lamp dark");
  store_group_a: assert property (nvm_write |-> nvm_write_group != 2'h0)
    else $error("store write without group");
  cover property (call_accept);
  cover property ($fell(configure_mode));
  cover property (unit_reset);
endmodule
bind ssc_panel ssc_panel_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC), .NCTL(NCTL)) chk (.*);

// ### testbench/ssc_op.sv
// operator at the touch panel and battery-backed word store
// assumes the bench calls press() from its main sequence
`timescale 1ns/1ps
module ssc_op (
  input wire ref_clk,
  input wire rst_b,
  input wire nvm_write,
  input wire [1:0] nvm_write_group,
  input wire [7:0] nvm_write_data,
  output logic [2:0] group_key = 3'h0,
  output logic [7:0] value_key = 8'h00,
  output logic [1:0] reset_key = 2'h0,
  output logic nvm_write_ack = 1'b0,
  output logic nvm_load_valid = 1'b0,
  output logic [7:0] nvm_load_one = 8'h00,
  output logic [7:0] nvm_load_two = 8'h00,
  output logic [7:0] nvm_load_three = 8'h00
);
  logic loaded = 1'b0;
  // words survive resets, as the real store does
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_write_ack <= 1'b0;
      nvm_load_valid <= 1'b0;
      loaded <= 1'b0;
    end else begin
      nvm_write_ack <= nvm_write;
      nvm_load_valid <= !loaded;
      loaded <= 1'b1;
      if (nvm_write) begin
        case (nvm_write_group)
          2'h1: nvm_load_one <= nvm_write_data;
          2'h2: nvm_load_two <= nvm_write_data;
          2'h3: nvm_load_three <= nvm_write_data;
          default: ;
        endcase
      end
    end
  end
  // one touch, held well past the debounce, keys released together
  task automatic press(input logic [2:0] g, input logic [7:0] v, input logic [1:0] r);
    @(posedge ref_clk);
    group_key <= g;
    value_key <= v;
    reset_key <= r;
    repeat (8) @(posedge ref_clk);
    group_key <= 3'h0;
    value_key <= 8'h00;
    reset_key <= 2'h0;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
endmodule

// ### testbench/tb.sv
// self-checking bench for the soft switch panel
// assumes ssc_op plays the operator and the store
`timescale 1ns/1ps
module tb;
  localparam TMO = 50;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] status_lamp = 8'hA5;
  logic battery_low = 1'b0;
  logic call_valid = 1'b0;
  logic [3:0] call_group = 4'h0;
  logic [5:0] ctl_level = 6'h05;
  logic [5:0] ctl_connected = 6'h0F;
  logic ext_trunk_clk = 1'b0;
  logic call_is_command = 1'b0;
  logic call_cmd_x121 = 1'b0;
  logic [1:0] call_subaddr_line = 2'h0;
  wire [1:0] call_line;
  wire trunk_clk_out, ext_clk_too_fast, call_to_command;
  wire [2:0] group_key;
  wire [7:0] value_key, lamps, nvm_load_one, nvm_load_two, nvm_load_three, nvm_write_data;
  wire [7:0] switch_group_one, switch_group_two, switch_group_three;
  wire [1:0] reset_key, nvm_write_group;
  wire [5:0] ctl_active;
  wire nvm_write, nvm_write_ack, nvm_load_valid, configure_mode, trunk_clk_int, call_accept, call_reject;
  integer fail_count = 0;
  integer compares = 0;
  always #20 ref_clk = ~ref_clk;
  ssc_panel #(.TIMEOUT_CYC(TMO), .DEBOUNCE_CYC(2), .NCTL(6)) dut (.*, .nvm_fail(1'b0),
    .indicator_lamp_1(lamps[0]),
    .indicator_lamp_2(lamps[1]), .indicator_lamp_3(lamps[2]), .indicator_lamp_4(lamps[3]),
    .config_alarm_lamp(lamps[4]), .indicator_lamp_6(lamps[5]), .indicator_lamp_7(lamps[6]),
    .indicator_lamp_8(lamps[7]), .unit_reset());
  ssc_op op (.*);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fail_count = fail_count + 1;
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // cycles between two toggles of the internal trunk clock
  task automatic trunk_half(output int n);
    logic was;
    was = trunk_clk_int;
    n = 0;
    while (trunk_clk_int == was) wait_cyc(1);
    was = trunk_clk_int;
    while (trunk_clk_int == was) begin
      wait_cyc(1);
      n = n + 1;
    end
  endtask
  // exp holds to_command, accept, reject; the answer stands one cycle only
  task automatic call(input logic [3:0] g, input logic [1:0] line, input logic cmd, input logic x,
    input logic [2:0] exp);
    @(posedge ref_clk);
    call_valid <= 1'b1;
    call_group <= g;
    call_subaddr_line <= line;
    call_is_command <= cmd;
    call_cmd_x121 <= x;
    @(posedge ref_clk);
    call_valid <= 1'b0;
    #1;
    chk("call", {3'h0, line, exp}, {3'h0, call_line, call_to_command, call_accept, call_reject});
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    wait_cyc(6000);
    fail_count = fail_count + 1;
    report_and_stop();
  end
  initial begin
    int n;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    wait_cyc(20);
    // 9600 bps at 25 MHz: 1302 cycles per half period
    trunk_half(n);
    chk("trunk_half_lo", 8'h16, n[7:0]);
    chk("trunk_half_hi", 8'h05, n[15:8]);
    wait_cyc(1);
    chk("trunk_own", {7'h00, trunk_clk_int}, {7'h00, trunk_clk_out});
    chk("lamps_status", 8'hA5, lamps);
    chk("ctl_bias_off", 8'h05, {2'h0, ctl_active});
    op.press(3'h1, 8'h00, 2'h0);
    chk("configure", 8'h01, {7'h00, configure_mode});
    chk("lamps_one", 8'h00, lamps);
    op.press(3'h0, 8'h02, 2'h0);
    chk("lamps_sel2", 8'h02, lamps);
    op.press(3'h0, 8'h80, 2'h0);
    chk("lamps_sel8", 8'h82, lamps);
    chk("stored_one", 8'h82, nvm_load_one);
    chk("live_one", 8'h00, switch_group_one);
    op.press(3'h2, 8'h00, 2'h0);
    chk("lamps_two", 8'h00, lamps);
    op.press(3'h0, 8'h01, 2'h0);
    op.press(3'h0, 8'h04, 2'h0);
    op.press(3'h0, 8'h10, 2'h0);
    chk("lamps_lgn", 8'h15, lamps);
    op.press(3'h4, 8'h00, 2'h0);
    op.press(3'h0, 8'h01, 2'h0);
    chk("lamps_three", 8'h01, lamps);
    $display("edit test done");
    wait_cyc(TMO + 10);
    @(posedge ref_clk);
    battery_low <= 1'b1;
    wait_cyc(4);
    chk("timed_out", 8'h00, {7'h00, configure_mode});
    chk("lamps_alarm", 8'hB5, lamps);
    op.press(3'h0, 8'h08, 2'h0);
    chk("ignored", 8'hB5, lamps);
    $display("timeout test done");
    op.press(3'h0, 8'h00, 2'h3);
    wait_cyc(4);
    chk("warm_one", 8'h82, switch_group_one);
    chk("warm_three", 8'h01, switch_group_three);
    chk("warm_two", 8'h15, switch_group_two);
    @(posedge ref_clk);
    ext_trunk_clk <= 1'b1;
    wait_cyc(2);
    chk("trunk_ext_hi", 8'h01, {7'h00, trunk_clk_out});
    chk("ext_slow", 8'h00, {7'h00, ext_clk_too_fast});
    @(posedge ref_clk);
    ext_trunk_clk <= 1'b0;
    wait_cyc(2);
    chk("trunk_ext_lo", 8'h00, {7'h00, trunk_clk_out});
    chk("ext_fast", 8'h01, {7'h00, ext_clk_too_fast});
    chk("ctl_bias_on", 8'h35, {2'h0, ctl_active});
    call(4'h0, 2'h1, 1'b1, 1'b0, 3'b110);
    call(4'h5, 2'h2, 1'b1, 1'b1, 3'b001);
    $display("warm test done");
    op.press(3'h1, 8'h00, 2'h0);
    chk("lamps_keep", 8'h82, lamps);
    op.press(3'h0, 8'h08, 2'h0);
    chk("lamps_cold", 8'h8A, lamps);
    op.press(3'h0, 8'h00, 2'h3);
    wait_cyc(4);
    chk("cold_cleared", 8'h82, switch_group_one);
    chk("cold_two", 8'h15, switch_group_two);
    call(4'h5, 2'h3, 1'b1, 1'b1, 3'b110);
    call(4'h0, 2'h0, 1'b0, 1'b0, 3'b001);
    $display("cold test done");
    report_and_stop();
  end
endmodule
